// *** pkg/lvdc_pkg.sv ***
package lvdc_pkg;
    // register byte offsets
    localparam logic [11:0] ctrl_off = 12'h000;
    localparam logic [11:0] irq_off = 12'h004;
    localparam logic [11:0] stat_off = 12'h008;
    // control register fields
    localparam int trip_lsb = 0;
    localparam int trip_w = 4;
    localparam int pwr_bit = 4;
    localparam int stable_bit = 5;
    localparam logic [3:0] trip_rst = 4'h5;
    localparam logic [7:0] ctrl_rst = 8'h05;
    localparam logic [3:0] trip_ext = 4'hf;
    localparam logic [3:0] trip_rsvd = 4'h0;
    // irq control register fields
    localparam int flag_bit = 0;
    localparam int ie_bit = 1;
    localparam int gie_bit = 2;
    // status register fields
    localparam int sleep_bit = 0;
    localparam int wake_bit = 1;
    localparam int vect_bit = 2;
    localparam int trip_bit = 3;
    // reference start-up time, fixed regardless of code running
    localparam int ref_settle_us = 50;
    localparam int clk_mhz = 40;
    localparam int ref_settle_cyc = ref_settle_us * clk_mhz;
    localparam int cnt_w = 12;
    typedef enum logic [1:0]
    {
        lvdc_off = 2'b00,
        lvdc_settle = 2'b01,
        lvdc_ready = 2'b10
    } lvdc_state_t;
endpackage : lvdc_pkg

// *** pkg/lvdc_sync_if.sv ***
`timescale 1ns/100ps
interface lvdc_sync_if;
    logic raw;
    logic clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface : lvdc_sync_if

// *** design/lvdc_sync.sv ***
`timescale 1ns/100ps
module lvdc_sync
(
    input wire logic pclk,
    input wire logic presetn,
    lvdc_sync_if.sync s
);
    logic [2:0] sh_q;
    logic clean_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sh_q <= 3'h0;
        else
            sh_q <= {sh_q[1:0], s.raw};
    end
    // a change counts only when stages two and three agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clean_q <= 1'b0;
        else if (sh_q[1] == sh_q[2])
            clean_q <= sh_q[2];
    end
    assign s.clean = clean_q;
endmodule : lvdc_sync

// *** design/lvdc_top.sv ***
// Behaviour
// - a comparator report of supply below the set point sets the low-voltage flag.
// - the trip point is picked by the four-bit trip level field in control bits 3:0.
// - trip level all ones routes the external trip input to the comparator.
// - codes 1 to 14 select internal thresholds ascending; code 0 is reserved.
// - control bit 4 powers the detector up when set and down when cleared.
// - read-only control bit 5 reads one once the detector can flag reliably.
// - control bits 7 and 6 read zero and ignore writes.
// - the flag is suppressed until the reference is stable after enabling.
// - the reference start-up wait is a fixed time, not tied to software clocking.
// - the detector keeps working in sleep; a trip then sets the flag and wakes.
// - after a detector wake the vector is taken only if global irq is enabled.
// - while awake the vector is taken when the flag, the irq enable and the global irq enable are set.
// - device reset returns the control register to reset, powering the detector off.
`timescale 1ns/100ps
module lvdc_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comp_below,
    input wire logic ref_ready,
    input wire logic external_trip_input,
    input wire logic sleep_mode,
    output logic detector_power_enable,
    output logic [3:0] trip_level_select,
    output logic ext_select,
    output logic comp_from_external,
    output logic wake_req,
    output logic vector_req
);
    logic [3:0] trip_q;
    logic pwr_q;
    logic flag_q;
    logic ie_q;
    logic gie_q;
    logic wake_q;
    logic vect_q;
    logic [lvdc_pkg::cnt_w-1:0] cnt_q;
    lvdc_pkg::lvdc_state_t state_q;
    logic stable;
    logic below;
    logic ext_pin;
    logic ref_ok;
    logic wr;
    logic rd;
    logic trip_ev;
    logic flag_clr;
    lvdc_sync_if cmp_if ();
    lvdc_sync_if pin_if ();
    lvdc_sync_if ref_if ();

    // analog inputs are asynchronous to pclk
    assign cmp_if.raw = comp_below;
    assign pin_if.raw = external_trip_input;
    assign ref_if.raw = ref_ready;
    lvdc_sync u_cmp (.pclk(pclk), .presetn(presetn), .s(cmp_if));
    lvdc_sync u_pin (.pclk(pclk), .presetn(presetn), .s(pin_if));
    lvdc_sync u_ref (.pclk(pclk), .presetn(presetn), .s(ref_if));
    assign below = cmp_if.clean;
    assign ext_pin = pin_if.clean;
    assign ref_ok = ref_if.clean;

    function automatic logic is_off(input logic [11:0] a, input logic [11:0] o);
        is_off = (a == o);
    endfunction : is_off

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(is_off(paddr, lvdc_pkg::ctrl_off)
        || is_off(paddr, lvdc_pkg::irq_off) || is_off(paddr, lvdc_pkg::stat_off));

    // control register; bits 7:6 have no storage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trip_q <= lvdc_pkg::trip_rst;
            pwr_q <= 1'b0;
        end
        else if (wr && is_off(paddr, lvdc_pkg::ctrl_off) && pstrb[0])
        begin
            trip_q <= pwdata[lvdc_pkg::trip_lsb +: lvdc_pkg::trip_w];
            pwr_q <= pwdata[lvdc_pkg::pwr_bit];
        end
    end

    // stable after both a fixed settle count and the analog ready level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= lvdc_pkg::lvdc_off;
            cnt_q <= '0;
        end
        else if (!pwr_q)
        begin
            state_q <= lvdc_pkg::lvdc_off;
            cnt_q <= '0;
        end
        else
        begin
            unique case (state_q)
                lvdc_pkg::lvdc_off:
                begin
                    state_q <= lvdc_pkg::lvdc_settle;
                    cnt_q <= '0;
                end
                lvdc_pkg::lvdc_settle:
                begin
                    // counted in pclk cycles of a fixed time constant
                    if (cnt_q == lvdc_pkg::cnt_w'(lvdc_pkg::ref_settle_cyc - 1))
                    begin
                        if (ref_ok)
                            state_q <= lvdc_pkg::lvdc_ready;
                    end
                    else
                        cnt_q <= cnt_q + 1'b1;
                end
                lvdc_pkg::lvdc_ready:
                    state_q <= lvdc_pkg::lvdc_ready;
                default:
                    state_q <= lvdc_pkg::lvdc_off;
            endcase
        end
    end
    assign stable = (state_q == lvdc_pkg::lvdc_ready);

    // external pin replaces the divider when level is all ones
    assign ext_select = (trip_q == lvdc_pkg::trip_ext);
    // the comparator output is already valid for either source; pin path is observed here
    assign comp_from_external = ext_select && ext_pin;
    // reserved code 0 never trips; software must avoid it
    assign trip_ev = stable && below && (trip_q != lvdc_pkg::trip_rsvd);

    assign flag_clr = wr && is_off(paddr, lvdc_pkg::irq_off) && pstrb[0]
        && !pwdata[lvdc_pkg::flag_bit];

    // set wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_q <= 1'b0;
        else if (trip_ev)
            flag_q <= 1'b1;
        else if (flag_clr)
            flag_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ie_q <= 1'b0;
            gie_q <= 1'b0;
        end
        else if (wr && is_off(paddr, lvdc_pkg::irq_off) && pstrb[0])
        begin
            ie_q <= pwdata[lvdc_pkg::ie_bit];
            gie_q <= pwdata[lvdc_pkg::gie_bit];
        end
    end

    // wake and vector requests, registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_q <= 1'b0;
            vect_q <= 1'b0;
        end
        else
        begin
            wake_q <= sleep_mode && flag_q && pwr_q;
            if (sleep_mode)
                vect_q <= 1'b0;
            else if (wake_q)
                vect_q <= gie_q && flag_q;
            else
                vect_q <= flag_q && ie_q && gie_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd)
        begin
            prdata <= 32'h00000000;
            if (is_off(paddr, lvdc_pkg::ctrl_off))
            begin
                prdata[lvdc_pkg::trip_lsb +: lvdc_pkg::trip_w] <= trip_q;
                prdata[lvdc_pkg::pwr_bit] <= pwr_q;
                prdata[lvdc_pkg::stable_bit] <= stable;
            end
            else if (is_off(paddr, lvdc_pkg::irq_off))
            begin
                prdata[lvdc_pkg::flag_bit] <= flag_q;
                prdata[lvdc_pkg::ie_bit] <= ie_q;
                prdata[lvdc_pkg::gie_bit] <= gie_q;
            end
            else if (is_off(paddr, lvdc_pkg::stat_off))
            begin
                prdata[lvdc_pkg::sleep_bit] <= sleep_mode;
                prdata[lvdc_pkg::wake_bit] <= wake_q;
                prdata[lvdc_pkg::vect_bit] <= vect_q;
                prdata[lvdc_pkg::trip_bit] <= below;
            end
        end
    end

    assign detector_power_enable = pwr_q;
    assign trip_level_select = trip_q;
    assign wake_req = wake_q;
    assign vector_req = vect_q;
endmodule : lvdc_top

// *** test/lvdc_asserts.sv ***
`timescale 1ns/100ps
module lvdc_asserts
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic sleep_mode,
    input wire logic detector_power_enable,
    input wire logic [3:0] trip_level_select,
    input wire logic ext_select,
    input wire logic comp_from_external,
    input wire logic wake_req
);
    logic wr_c;
    logic rd_c;
    assign wr_c = psel && penable && pwrite && pstrb[0] && paddr == lvdc_pkg::ctrl_off;
    assign rd_c = psel && penable && !pwrite && paddr == lvdc_pkg::ctrl_off;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_trip_load: assert property (wr_c |=> trip_level_select == $past(pwdata[3:0]))
        else $error("trip level not loaded");
    a_trip_hold: assert property (!wr_c |=> $stable(trip_level_select))
        else $error("trip level moved without write");
    a_pwr_load: assert property (wr_c |=> detector_power_enable == $past(pwdata[4]))
        else $error("power enable not loaded");
    a_ext_decode: assert property (ext_select == (trip_level_select == lvdc_pkg::trip_ext))
        else $error("external select decode wrong");
    a_ext_route: assert property (!ext_select |-> !comp_from_external)
        else $error("external pin routed while not selected");
    a_rsv_zero: assert property (rd_c |-> prdata[7:6] == 2'b00)
        else $error("unimplemented control bits read nonzero");
    a_stable_off: assert property (rd_c && !$past(detector_power_enable)
        && !$past(detector_power_enable, 2) |-> !prdata[5])
        else $error("stable bit set while powered down");
    a_wake_cause: assert property (wake_req |-> $past(sleep_mode) && $past(detector_power_enable))
        else $error("wake without sleep and power");
    c_wake: cover property (wake_req);
    c_ext: cover property (comp_from_external);
    c_stable: cover property (rd_c && prdata[5]);
endmodule : lvdc_asserts

bind lvdc_top lvdc_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .sleep_mode(sleep_mode), .detector_power_enable(detector_power_enable),
    .trip_level_select(trip_level_select), .ext_select(ext_select),
    .comp_from_external(comp_from_external), .wake_req(wake_req));

// *** test/lvdc_top_tb.sv ***
`timescale 1ns/100ps
module lvdc_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic comp_below = 0, ref_ready = 0, external_trip_input = 0, sleep_mode = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, d, ctrl_m;
    logic [3:0] pstrb = 4'hf, trip_level_select;
    logic pready, pslverr, detector_power_enable, ext_select, comp_from_external;
    logic wake_req, vector_req;
    int errors = 0, compares = 0, n, seed = 32'he363;
    lvdc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .comp_below(comp_below), .ref_ready(ref_ready),
        .external_trip_input(external_trip_input), .sleep_mode(sleep_mode),
        .detector_power_enable(detector_power_enable), .trip_level_select(trip_level_select),
        .ext_select(ext_select), .comp_from_external(comp_from_external),
        .wake_req(wake_req), .vector_req(vector_req));
    always #12.5 pclk = ~pclk;
    task summarize;
        if (errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // zero-wait slave, but the loop keeps the master honest if pready ever drops
    task apb(input logic w, input logic [11:0] a, input logic [31:0] dd);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dd;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(nm, e, rd);
    endtask : rdc
    initial
    begin
        #(25 * 20000);
        errors++;
        summarize;
    end
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        rdc("ctrl_rst", lvdc_pkg::ctrl_off, {24'h0, lvdc_pkg::ctrl_rst});
        rdc("irq_rst", lvdc_pkg::irq_off, 0);
        for (int c = 0; c < 16; c++)
        begin
            d = ($random(seed) & 32'hffffffe0) | c;
            ctrl_m = d & 32'h1f;
            apb(1, lvdc_pkg::ctrl_off, d);
            rdc("ctrl_rw", lvdc_pkg::ctrl_off, ctrl_m);
            chk("trip_out", c, trip_level_select);
            chk("ext_sel", c == 15, ext_select);
        end
        apb(0, 12'h00c, 0);
        chk("unmapped_rd", 0, rd);
        chk("unmapped_err", 1, er);
        apb(1, lvdc_pkg::ctrl_off, 32'h15);
        ref_ready <= 1;
        comp_below <= 1;
        repeat (20) @(posedge pclk);
        rdc("flag_held", lvdc_pkg::irq_off, 0);
        comp_below <= 0;
        n = 0;
        do
        begin
            apb(0, lvdc_pkg::ctrl_off, 0);
            n++;
        end while (rd[5] !== 1'b1 && n < 2000);
        chk("stable_rd", 32'h35, rd);
        // polling started about 24 cycles after the enable write
        chk("settle_long", 1, n * 3 + 24 >= lvdc_pkg::ref_settle_cyc);
        apb(1, lvdc_pkg::irq_off, 0);
        apb(1, lvdc_pkg::irq_off, 32'h6);
        comp_below <= 1;
        repeat (6) @(posedge pclk);
        rdc("flag_set", lvdc_pkg::irq_off, 32'h7);
        chk("vec_awake", 1, vector_req);
        for (int g = 1; g >= 0; g--)
        begin
            comp_below <= 0;
            sleep_mode <= 0;
            repeat (6) @(posedge pclk);
            apb(1, lvdc_pkg::irq_off, 32'h2 | (g << 2));
            sleep_mode <= 1;
            comp_below <= 1;
            repeat (8) @(posedge pclk);
            chk("wake", 1, wake_req);
            // the core leaves sleep on the wake request; the vector follows a cycle later
            sleep_mode <= 0;
            repeat (2) @(posedge pclk);
            chk("vec_sleep", g, vector_req);
        end
        sleep_mode <= 0;
        apb(1, lvdc_pkg::ctrl_off, 32'h05);
        rdc("pwr_off", lvdc_pkg::ctrl_off, 32'h05);
        apb(1, lvdc_pkg::ctrl_off, 32'h1f);
        external_trip_input <= 1;
        repeat (5) @(posedge pclk);
        chk("ext_route", 1, comp_from_external);
        presetn <= 0;
        repeat (5) @(posedge pclk);
        presetn <= 1;
        rdc("ctrl_rst2", lvdc_pkg::ctrl_off, 32'h05);
        summarize;
    end
endmodule : lvdc_top_tb
